// ==== verilog/debug_uart_regs.vh ====
// Register addresses, field positions, codes and timing counts for the debug serial port and reload timer.
`ifndef DEBUG_UART_REGS_VH
`define DEBUG_UART_REGS_VH

// Special function register addresses.
`define SFR_SERIAL_CTRL 8'h98
`define SFR_SERIAL_BUF 8'h99
`define SFR_TIMER_CTRL 8'hc8
`define SFR_TIMER_MODE 8'hc9
`define SFR_RELOAD_LO 8'hca
`define SFR_RELOAD_HI 8'hcb
`define SFR_COUNT_LO 8'hcc
`define SFR_COUNT_HI 8'hcd

// Serial control and status bit positions.
`define SC_MODE_A 7
`define SC_MODE_B 6
`define SC_MPF 5
`define SC_REN 4
`define SC_TX9 3
`define SC_RX9 2
`define SC_TDONE 1
`define SC_RDONE 0

// Timer control and timer mode bit positions.
`define TC_WRAP 7
`define TC_RXSEL 5
`define TC_TXSEL 4
`define TC_RUN 2
`define TM_TORN 2
`define TM_DIR 0

// Serial modes as {mode_select_bit_a, mode_select_bit_b}.
`define MODE_SHIFT 2'h0
`define MODE_ASYNC8 2'h1
`define MODE_FIXED9 2'h2
`define MODE_TIMED9 2'h3

// Reset values and the all-ones count.
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define COUNT_ALL_ONES 16'hffff

// Machine cycle of six clocks: last phase and last low phase of the shift clock.
`define MC_LAST 3'h5
`define MC_HALF 3'h2

// Sixteen oversample ticks per bit; mid-bit sample point.
`define OVS_LAST 4'hf
`define OVS_MID 4'h7

// Frame lengths in bits and shift-mode data length.
`define FRAME_BITS8 4'ha
`define FRAME_BITS9 4'hb
`define SHIFT_LAST_BIT 4'h7
`define DONE_BITS_LEFT 4'h2
`define LAST_BIT_LEFT 4'h1

`endif

// ==== verilog/uart_bit_divider.v ====
// Divides oversample ticks into mid-bit and end-of-bit strobes for one direction.
`timescale 1ns/1ps
`default_nettype none
`include "debug_uart_regs.vh"

module uart_bit_divider (
   input wire clk_sys_in, // System clock.
   input wire rst_in, // Asynchronous reset, active high.
   input wire restart_in, // Restarts the bit at tick zero.
   input wire tick_in, // Oversample tick, counted once per clock while high.
   output wire mid_out, // Mid-bit strobe.
   output wire end_out // End-of-bit strobe.
);

   reg [3:0] ovs_q;
   reg [3:0] ovs_d;

   // Strobes are combinational so the engines act on the same tick.
   assign mid_out = tick_in && !restart_in && (ovs_q == `OVS_MID);
   assign end_out = tick_in && !restart_in && (ovs_q == `OVS_LAST);

   // A restart aligns the bit to the start edge; the counter wraps naturally at sixteen.
   always @* begin
      ovs_d = ovs_q;
      if (restart_in) begin
         ovs_d = 4'h0;
      end else if (tick_in) begin
         ovs_d = ovs_q + 4'h1;
      end
   end

   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ovs_q <= 4'h0;
      end else begin
         ovs_q <= ovs_d;
      end
   end

endmodule // uart_bit_divider
`default_nettype wire

// ==== verilog/debug_uart_reload_timer.v ====
// Debug serial port with four modes and the 16-bit auto-reload timer that can clock it.
`timescale 1ns/1ps
`default_nettype none
`include "debug_uart_regs.vh"

// Summary of operation
// - Flag high-byte change between low and high reads.
// - Direction bit selects up or down counting outside baud generation mode.
// - Low and high bytes form one 16-bit counter.
// - Reload copies reload bytes into count bytes.
// - One received byte buffered; overrun loses one.
// - Buffer write transmits, read returns receive register.
// - Shift mode: eight bits, clock out, sixth rate.
// - Eight-bit mode: start, eight data, stop.
// - Eight-bit mode stores stop bit as ninth.
// - Eight-bit mode rate from timer overflows.
// - Nine-bit frame, ninth bit from transmit field.
// - Nine-bit receive stores ninth, ignores stop.
// - Fixed nine-bit mode runs at sixteenth or thirty-second.
// - Timed nine-bit mode framed as fixed, timer rate.
// - Any buffer write starts transmission.
// - Shift receive starts when done clear, enabled.
// - Async receive starts on start bit if enabled.
// - Clock select bits pick reload timer overflows.
// - Transmit done after ninth or eighth bit.
// - Filter drops frames with zero ninth bit.
// - No wrap flag in baud generation mode.
module debug_uart_reload_timer (
   input wire clk_sys_in, // System clock, 250 MHz.
   input wire rst_in, // Asynchronous reset, active high.
   input wire [7:0] sfr_addr_in, // Register address.
   input wire [7:0] sfr_wdata_in, // Write data.
   input wire sfr_wr_in, // Write strobe, one cycle.
   input wire sfr_rd_in, // Read strobe, one cycle.
   output wire [7:0] sfr_rdata_out, // Read data, valid the cycle after the strobe.
   input wire uart_rx_in, // Receive pin level.
   output wire uart_rx_out, // Receive pin drive value in shift mode.
   output wire uart_rx_oe_out, // Receive pin drive enable, high while driving.
   output wire uart_tx_out, // Transmit pin, or shift clock in shift mode.
   input wire other_baud_ovf_in, // Overflow pulse of the other baud timer.
   input wire mode2_half_rate_in, // High selects one thirty-second rate in fixed mode.
   output wire reload_timer_ovf_out // Reload timer overflow pulse.
);

   // Register state.
   reg mode_a_q, mode_b_q, mpf_q, ren_q, tx9_q, rx9_q, tdone_q, rdone_q;
   reg [7:0] rx_buf_q;
   reg wrap_q, rxsel_q, txsel_q, run_q, dir_q, torn_q, torn_armed_q;
   reg [15:0] count_q, count_d, reload_q;
   reg [7:0] rdata_q;
   reg rd_low_q;
   reg [2:0] mc_q;
   reg half_q;
   reg rx_sync1_q, rx_sync2_q, rx_prev_q;
   // Async transmit engine.
   reg tx_busy_q, tx_line_q;
   reg [10:0] tx_shift_q;
   reg [3:0] tx_left_q;
   // Async receive engine.
   reg rx_active_q, rx_first_q;
   reg [9:0] rx_shift_q;
   reg [3:0] rx_left_q;
   // Shift-mode engine.
   reg m0_active_q, m0_is_rx_q, m0_clk_q;
   reg [2:0] m0_phase_q;
   reg [3:0] m0_cnt_q;
   reg [7:0] m0_shift_q;

   wire [1:0] mode = {mode_a_q, mode_b_q};
   wire nine_bit = mode_a_q;
   wire wr_sc = sfr_wr_in && (sfr_addr_in == `SFR_SERIAL_CTRL);
   wire wr_buf = sfr_wr_in && (sfr_addr_in == `SFR_SERIAL_BUF);
   wire wr_tc = sfr_wr_in && (sfr_addr_in == `SFR_TIMER_CTRL);
   wire wr_tm = sfr_wr_in && (sfr_addr_in == `SFR_TIMER_MODE);
   wire wr_rl = sfr_wr_in && (sfr_addr_in == `SFR_RELOAD_LO);
   wire wr_rh = sfr_wr_in && (sfr_addr_in == `SFR_RELOAD_HI);
   wire wr_cl = sfr_wr_in && (sfr_addr_in == `SFR_COUNT_LO);
   wire wr_ch = sfr_wr_in && (sfr_addr_in == `SFR_COUNT_HI);
   wire rd_low = sfr_rd_in && (sfr_addr_in == `SFR_COUNT_LO);
   wire rd_high = sfr_rd_in && (sfr_addr_in == `SFR_COUNT_HI);

   // Reload timer stepping once per machine cycle of six clocks.
   wire baud_mode = rxsel_q || txsel_q;
   wire mc_tick = (mc_q == `MC_LAST);
   wire step = run_q && mc_tick;
   wire count_up = dir_q || baud_mode;
   wire t_ovf_up = step && count_up && (count_q == `COUNT_ALL_ONES);
   wire t_ovf_dn = step && !count_up && (count_q == reload_q);
   wire t_ovf = t_ovf_up || t_ovf_dn;
   reg [15:0] hw_count;

   assign reload_timer_ovf_out = t_ovf;

   // Both bytes step as one word; firmware writes win over the hardware update of that byte.
   always @* begin
      hw_count = count_q;
      if (t_ovf_up) begin
         hw_count = reload_q;
      end else if (t_ovf_dn) begin
         hw_count = `COUNT_ALL_ONES;
      end else if (step && count_up) begin
         hw_count = count_q + 16'h0001;
      end else if (step) begin
         hw_count = count_q - 16'h0001;
      end
      count_d = hw_count;
      if (wr_cl) begin
         count_d[7:0] = sfr_wdata_in;
      end
      if (wr_ch) begin
         count_d[15:8] = sfr_wdata_in;
      end
   end

   wire high_hw_change = !wr_ch && (hw_count[15:8] != count_q[15:8]);
   // Clear acts on the cycle after a low-byte read strobe ends.
   wire torn_clear = rd_low_q && !rd_low;

   // Oversample tick sources per direction.
   wire fixed_tick = !mode2_half_rate_in || half_q;
   wire rx_timer_tick = rxsel_q ? t_ovf : other_baud_ovf_in;
   wire tx_timer_tick = txsel_q ? t_ovf : other_baud_ovf_in;
   wire rx_tick = (mode == `MODE_FIXED9) ? fixed_tick : rx_timer_tick;
   wire tx_tick = (mode == `MODE_FIXED9) ? fixed_tick : tx_timer_tick;

   // Transmit engine strobes.
   wire tx_start = wr_buf && (mode != `MODE_SHIFT);
   wire tx_end;
   uart_bit_divider u_tx_div (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .restart_in(tx_start),
      .tick_in(tx_tick),
      .mid_out(),
      .end_out(tx_end)
   );
   wire tx_bit_end = tx_busy_q && tx_end;
   wire tx_done_evt = tx_bit_end && (tx_left_q == `DONE_BITS_LEFT);

   // Receive engine strobes.
   wire rx_start = !rx_active_q && ren_q && (mode != `MODE_SHIFT) && rx_prev_q && !rx_sync2_q;
   wire rx_mid;
   uart_bit_divider u_rx_div (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .restart_in(rx_start),
      .tick_in(rx_tick),
      .mid_out(rx_mid),
      .end_out()
   );
   wire rx_sample = rx_active_q && rx_mid;
   wire [9:0] rx_word = {rx_sync2_q, rx_shift_q[9:1]};
   wire rx_final = rx_sample && !rx_first_q && (rx_left_q == `LAST_BIT_LEFT);
   wire [7:0] rx_data = nine_bit ? rx_word[7:0] : rx_word[8:1];
   wire rx_ninth = nine_bit ? rx_word[8] : rx_word[9];
   // A frame is taken only when the receive done flag is clear and the filter passes it.
   wire rx_accept = rx_final && !rdone_q && !(mpf_q && !rx_ninth);

   // Shift-mode strobes: six clocks per bit.
   wire m0_rx_start = (mode == `MODE_SHIFT) && !m0_active_q && ren_q && !rdone_q && !wr_buf;
   wire m0_tx_start = (mode == `MODE_SHIFT) && wr_buf;
   wire m0_bit_end = m0_active_q && (m0_phase_q == `MC_LAST);
   wire m0_last = m0_bit_end && (m0_cnt_q == `SHIFT_LAST_BIT);
   wire m0_tx_done = m0_last && !m0_is_rx_q;
   wire m0_rx_done = m0_last && m0_is_rx_q;

   // Serial control and status register; hardware sets win over firmware clears.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         mode_a_q <= 1'b0;
         mode_b_q <= 1'b0;
         mpf_q <= 1'b0;
         ren_q <= 1'b0;
         tx9_q <= 1'b0;
         rx9_q <= 1'b0;
         tdone_q <= 1'b0;
         rdone_q <= 1'b0;
         rx_buf_q <= `RST_BYTE;
      end else begin
         if (wr_sc) begin
            mode_a_q <= sfr_wdata_in[`SC_MODE_A];
            mode_b_q <= sfr_wdata_in[`SC_MODE_B];
            mpf_q <= sfr_wdata_in[`SC_MPF];
            ren_q <= sfr_wdata_in[`SC_REN];
            tx9_q <= sfr_wdata_in[`SC_TX9];
         end
         if (rx_accept) begin
            rx9_q <= rx_ninth;
         end else if (wr_sc) begin
            rx9_q <= sfr_wdata_in[`SC_RX9];
         end
         if (tx_done_evt || m0_tx_done) begin
            tdone_q <= 1'b1;
         end else if (wr_sc) begin
            tdone_q <= sfr_wdata_in[`SC_TDONE];
         end
         if (rx_accept || m0_rx_done) begin
            rdone_q <= 1'b1;
         end else if (wr_sc) begin
            rdone_q <= sfr_wdata_in[`SC_RDONE];
         end
         // The receive register is separate from the transmit shifter.
         if (rx_accept) begin
            rx_buf_q <= rx_data;
         end else if (m0_rx_done) begin
            rx_buf_q <= m0_shift_q;
         end
      end
   end

   // Timer control, mode, reload and count registers.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wrap_q <= 1'b0;
         rxsel_q <= 1'b0;
         txsel_q <= 1'b0;
         run_q <= 1'b0;
         dir_q <= 1'b0;
         torn_q <= 1'b0;
         torn_armed_q <= 1'b0;
         rd_low_q <= 1'b0;
         reload_q <= `RST_WORD;
         count_q <= `RST_WORD;
      end else begin
         count_q <= count_d;
         rd_low_q <= rd_low;
         if (wr_tc) begin
            rxsel_q <= sfr_wdata_in[`TC_RXSEL];
            txsel_q <= sfr_wdata_in[`TC_TXSEL];
            run_q <= sfr_wdata_in[`TC_RUN];
         end
         // Overflow in baud generation mode never raises the wrap flag.
         if (t_ovf && !baud_mode) begin
            wrap_q <= 1'b1;
         end else if (wr_tc) begin
            wrap_q <= wrap_q && sfr_wdata_in[`TC_WRAP];
         end
         if (wr_tm) begin
            dir_q <= sfr_wdata_in[`TM_DIR];
         end
         if (wr_rl) begin
            reload_q[7:0] <= sfr_wdata_in;
         end
         if (wr_rh) begin
            reload_q[15:8] <= sfr_wdata_in;
         end
         // Armed from a low-byte read until the following high-byte read.
         if (rd_low) begin
            torn_armed_q <= 1'b1;
         end else if (rd_high) begin
            torn_armed_q <= 1'b0;
         end
         if (torn_armed_q && high_hw_change) begin
            torn_q <= 1'b1;
         end else if (torn_clear) begin
            torn_q <= 1'b0;
         end
      end
   end

   // Read data is registered; unmapped addresses read zero.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= `RST_BYTE;
      end else if (sfr_rd_in) begin
         case (sfr_addr_in)
            `SFR_SERIAL_CTRL: rdata_q <= {mode_a_q, mode_b_q, mpf_q, ren_q, tx9_q, rx9_q, tdone_q, rdone_q};
            `SFR_SERIAL_BUF: rdata_q <= rx_buf_q;
            `SFR_TIMER_CTRL: rdata_q <= {wrap_q, 1'b0, rxsel_q, txsel_q, 1'b0, run_q, 2'b00};
            `SFR_TIMER_MODE: rdata_q <= {5'b00000, torn_q, 1'b0, dir_q};
            `SFR_RELOAD_LO: rdata_q <= reload_q[7:0];
            `SFR_RELOAD_HI: rdata_q <= reload_q[15:8];
            `SFR_COUNT_LO: rdata_q <= count_q[7:0];
            `SFR_COUNT_HI: rdata_q <= count_q[15:8];
            default: rdata_q <= `RST_BYTE;
         endcase
      end
   end

   assign sfr_rdata_out = rdata_q;

   // Machine-cycle prescaler, fixed-rate half toggle and receive pin synchroniser.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         mc_q <= 3'h0;
         half_q <= 1'b0;
         rx_sync1_q <= 1'b1;
         rx_sync2_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         mc_q <= mc_tick ? 3'h0 : mc_q + 3'h1;
         half_q <= !half_q;
         rx_sync1_q <= uart_rx_in;
         rx_sync2_q <= rx_sync1_q;
         rx_prev_q <= rx_sync2_q;
      end
   end

   // Async transmitter: frame is shifted LSB first, line idles high.
   // A write while busy restarts the frame; firmware is expected to wait for the done flag.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         tx_busy_q <= 1'b0;
         tx_line_q <= 1'b1;
         tx_shift_q <= 11'h7ff;
         tx_left_q <= 4'h0;
      end else if (tx_start) begin
         tx_busy_q <= 1'b1;
         tx_line_q <= 1'b0;
         if (nine_bit) begin
            tx_shift_q <= {1'b1, tx9_q, sfr_wdata_in, 1'b0};
            tx_left_q <= `FRAME_BITS9;
         end else begin
            tx_shift_q <= {2'b11, sfr_wdata_in, 1'b0};
            tx_left_q <= `FRAME_BITS8;
         end
      end else if (mode == `MODE_SHIFT) begin
         tx_busy_q <= 1'b0;
         tx_line_q <= 1'b1;
      end else if (tx_bit_end) begin
         tx_shift_q <= {1'b1, tx_shift_q[10:1]};
         tx_line_q <= tx_shift_q[1];
         tx_left_q <= tx_left_q - 4'h1;
         if (tx_left_q == `LAST_BIT_LEFT) begin
            tx_busy_q <= 1'b0;
            tx_line_q <= 1'b1;
         end
      end
   end

   // Async receiver: start bit is rechecked at mid-bit to reject glitches.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rx_active_q <= 1'b0;
         rx_first_q <= 1'b0;
         rx_shift_q <= 10'h000;
         rx_left_q <= 4'h0;
      end else if (rx_start) begin
         rx_active_q <= 1'b1;
         rx_first_q <= 1'b1;
         rx_left_q <= nine_bit ? `FRAME_BITS9 - 4'h1 : `FRAME_BITS8 - 4'h1;
      end else if (!ren_q || (mode == `MODE_SHIFT)) begin
         rx_active_q <= 1'b0;
      end else if (rx_sample && rx_first_q) begin
         rx_first_q <= 1'b0;
         rx_active_q <= !rx_sync2_q;
      end else if (rx_sample) begin
         rx_shift_q <= rx_word;
         rx_left_q <= rx_left_q - 4'h1;
         if (rx_left_q == `LAST_BIT_LEFT) begin
            rx_active_q <= 1'b0;
         end
      end
   end

   // Shift mode: clock low for three clocks, high for three; data sampled before the rising edge.
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         m0_active_q <= 1'b0;
         m0_is_rx_q <= 1'b0;
         m0_clk_q <= 1'b1;
         m0_phase_q <= 3'h0;
         m0_cnt_q <= 4'h0;
         m0_shift_q <= `RST_BYTE;
      end else if (m0_tx_start || m0_rx_start) begin
         m0_active_q <= 1'b1;
         m0_is_rx_q <= m0_rx_start;
         m0_clk_q <= 1'b0;
         m0_phase_q <= 3'h0;
         m0_cnt_q <= 4'h0;
         m0_shift_q <= m0_tx_start ? sfr_wdata_in : `RST_BYTE;
      end else if (mode != `MODE_SHIFT) begin
         m0_active_q <= 1'b0;
         m0_clk_q <= 1'b1;
      end else if (m0_active_q) begin
         m0_phase_q <= m0_bit_end ? 3'h0 : m0_phase_q + 3'h1;
         m0_clk_q <= m0_bit_end ? m0_last : (m0_phase_q >= `MC_HALF);
         if (m0_is_rx_q && (m0_phase_q == `MC_HALF)) begin
            m0_shift_q <= {rx_sync2_q, m0_shift_q[7:1]};
         end
         if (m0_bit_end) begin
            if (!m0_is_rx_q) begin
               m0_shift_q <= {1'b0, m0_shift_q[7:1]};
            end
            m0_cnt_q <= m0_cnt_q + 4'h1;
            if (m0_last) begin
               m0_active_q <= 1'b0;
            end
         end
      end
   end

   // Pins: in shift mode the transmit pin carries the clock and the receive pin carries data.
   assign uart_tx_out = (mode == `MODE_SHIFT) ? m0_clk_q : tx_line_q;
   assign uart_rx_out = m0_shift_q[0];
   assign uart_rx_oe_out = m0_active_q && !m0_is_rx_q;

endmodule // debug_uart_reload_timer
`default_nettype wire

// ==== verification/debug_uart_reload_timer_chk.sv ====
// Pin-level checks on the debug serial port and reload timer.
`timescale 1ns/1ps
`default_nettype none
module debug_uart_reload_timer_chk (
   input wire logic clk_sys_in, // System clock.
   input wire logic rst_in, // Reset, active high.
   input wire logic [7:0] sfr_addr_in, // Register address.
   input wire logic [7:0] sfr_wdata_in, // Write data.
   input wire logic sfr_wr_in, // Write strobe.
   input wire logic sfr_rd_in, // Read strobe.
   input wire logic [7:0] sfr_rdata_out, // Read data.
   input wire logic uart_rx_out, // Shift data drive.
   input wire logic uart_rx_oe_out, // Shift data enable.
   input wire logic uart_tx_out, // Line or shift clock.
   input wire logic reload_timer_ovf_out // Timer overflow pulse.
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // Shift clock shape and data timing while the device drives data.
   shift_low_phase_a: assert property ($fell(uart_tx_out) && uart_rx_oe_out |-> (!uart_tx_out) [*3] ##1 uart_tx_out)
      else $error("shift clock low phase wrong");
   shift_data_hold_a: assert property (uart_rx_oe_out && $rose(uart_tx_out) |-> $stable(uart_rx_out))
      else $error("shift data moved at clock rise");
   shift_start_low_a: assert property ($rose(uart_rx_oe_out) |-> !uart_tx_out)
      else $error("shift clock not low at first bit");
   shift_idle_high_a: assert property ($fell(uart_rx_oe_out) |-> uart_tx_out)
      else $error("shift clock not idle high at end");
   // A buffer write pulls the pin low on the next edge in every mode.
   tx_start_low_a: assert property (sfr_wr_in && sfr_addr_in == 8'h99 |=> !uart_tx_out)
      else $error("transmit did not start");
   // The timer steps once per six clocks, so overflows are spaced.
   ovf_spacing_a: assert property (reload_timer_ovf_out |=> (!reload_timer_ovf_out) [*5])
      else $error("overflow pulses too close");
   // Read data only moves after a read strobe.
   rdata_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
      else $error("read data moved without a read");
   mode_reserved_a: assert property (sfr_rd_in && sfr_addr_in == 8'hc9 |=> sfr_rdata_out[7:3] == 5'h00 && !sfr_rdata_out[1])
      else $error("reserved timer mode bits not zero");
   reload_keep_a: assert property (sfr_wr_in && sfr_addr_in == 8'hca ##2 sfr_rd_in && sfr_addr_in == 8'hca
      |=> sfr_rdata_out == $past(sfr_wdata_in, 3))
      else $error("reload low byte lost its value");
endmodule // debug_uart_reload_timer_chk
bind debug_uart_reload_timer debug_uart_reload_timer_chk chk_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
   .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
   .sfr_rdata_out(sfr_rdata_out), .uart_rx_out(uart_rx_out), .uart_rx_oe_out(uart_rx_oe_out),
   .uart_tx_out(uart_tx_out), .reload_timer_ovf_out(reload_timer_ovf_out));
`default_nettype wire

// ==== verification/debug_peer_model.sv ====
// Serial peer standing on the debug port pins.
`timescale 1ns/1ps
`default_nettype none
module debug_peer_model (
   input wire logic clk_sys_in, // System clock.
   input wire logic line_in, // Device transmit pin.
   input wire logic shift_data_in, // Resolved receive pin.
   output logic line_out // Drive onto the receive pin.
);
   // The line idles high as through a pull-up, so no stale bit lingers.
   initial line_out = 1'b1;
   // Sends n bits first bit first, cyc clocks each, then releases the line.
   task automatic send(input logic [10:0] bits, input int n, input int cyc);
      for (int i = 0; i < n; i++) begin
         line_out <= bits[i];
         repeat (cyc) @(posedge clk_sys_in);
      end
      line_out <= 1'b1;
   endtask
   // Waits for a start edge and samples each bit at its middle.
   task automatic recv(input int n, input int cyc, output logic [10:0] bits);
      bits = 11'h000;
      @(negedge line_in);
      repeat (cyc / 2) @(posedge clk_sys_in);
      for (int i = 0; i < n; i++) begin
         bits[i] = line_in;
         repeat (cyc) @(posedge clk_sys_in);
      end
   endtask
   // Takes one shift byte on the rising shift clock.
   task automatic shift_recv(output logic [7:0] data);
      for (int i = 0; i < 8; i++) begin
         @(posedge line_in);
         data[i] = shift_data_in;
      end
   endtask
endmodule // debug_peer_model
`default_nettype wire

// ==== verification/debug_uart_reload_timer_test.sv ====
// Register level tests of the debug serial port and reload timer.
`timescale 1ns/1ps
`default_nettype none
module debug_uart_reload_timer_test;
   logic clk_sys_in, rst_in, sfr_wr_in, sfr_rd_in, other_baud_ovf_in, mode2_half_rate_in;
   logic [7:0] sfr_addr_in, sfr_wdata_in, v;
   logic [1:0] div_q;
   logic [10:0] frm;
   wire [7:0] sfr_rdata_out;
   wire uart_rx_out, uart_rx_oe_out, uart_tx_out, reload_timer_ovf_out, peer_line, rx_pin;
   int err_total, num_checks;
   // The device wins the receive pin only while it drives shift data.
   assign rx_pin = uart_rx_oe_out ? uart_rx_out : peer_line;
   debug_uart_reload_timer uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in),
      .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out),
      .uart_rx_in(rx_pin), .uart_rx_out(uart_rx_out), .uart_rx_oe_out(uart_rx_oe_out), .uart_tx_out(uart_tx_out),
      .other_baud_ovf_in(other_baud_ovf_in), .mode2_half_rate_in(mode2_half_rate_in),
      .reload_timer_ovf_out(reload_timer_ovf_out));
   debug_peer_model peer (.clk_sys_in(clk_sys_in), .line_in(uart_tx_out), .shift_data_in(rx_pin),
      .line_out(peer_line));
   // Clock of 4 ns.
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   // Other baud source pulses every fourth clock, so a bit lasts 64 clocks.
   always @(posedge clk_sys_in) begin
      div_q <= div_q + 2'h1;
      other_baud_ovf_in <= (div_q == 2'h3);
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [10:0] e, input logic [10:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", what, e, g);
      end
   endtask
   // The extra edge keeps back-to-back calls from driving a strobe twice at once.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_in <= a;
      sfr_wdata_in <= d;
      sfr_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      sfr_wr_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr_in <= a;
      sfr_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      sfr_rd_in <= 1'b0;
      @(posedge clk_sys_in);
      d = sfr_rdata_out;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), {3'h0, e}, {3'h0, d});
   endtask
   task automatic wait_ovf();
      for (int i = 0; i < 100 && reload_timer_ovf_out !== 1'b1; i++) @(posedge clk_sys_in);
   endtask
   // A hung wait ends the run as a failure.
   initial begin
      repeat (40000) @(posedge clk_sys_in);
      err_total++;
      conclude();
   end
   // Main sequence.
   initial begin
      {sfr_wr_in, sfr_rd_in, other_baud_ovf_in, mode2_half_rate_in, div_q} = 6'h00;
      {sfr_addr_in, sfr_wdata_in} = 16'h0000;
      rst_in = 1'b1;
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      rc(8'h98, 8'h00);
      for (int a = 'hc8; a <= 'hcd; a++) rc(a[7:0], 8'h00);
      wr(8'hc9, 8'hff);
      rc(8'hc9, 8'h01);
      wr(8'h00, 8'h5a);
      rc(8'h00, 8'h00);
      // Count up through all ones into the reload value.
      wr(8'hcb, 8'h12);
      wr(8'hca, 8'h34);
      rc(8'hca, 8'h34);
      wr(8'hcc, 8'hfe);
      wr(8'hcd, 8'hff);
      wr(8'hc8, 8'h04);
      wait_ovf();
      wr(8'hc8, 8'h80);
      rc(8'hcc, 8'h34);
      rc(8'hcd, 8'h12);
      rc(8'hc8, 8'h80);
      // Count down to the reload value, then to all ones.
      wr(8'hc9, 8'h00);
      wr(8'hca, 8'h10);
      wr(8'hcb, 8'h00);
      wr(8'hcc, 8'h11);
      wr(8'hcd, 8'h00);
      wr(8'hc8, 8'h04);
      wait_ovf();
      wr(8'hc8, 8'h00);
      rc(8'hcc, 8'hff);
      rc(8'hcd, 8'hff);
      // High byte moves between the two reads; two steps away so the low read comes first.
      wr(8'hc9, 8'h01);
      wr(8'hcc, 8'hfe);
      wr(8'hcd, 8'h05);
      wr(8'hc8, 8'h04);
      rd(8'hcc, v);
      repeat (12) @(posedge clk_sys_in);
      rd(8'hcd, v);
      rc(8'hc9, 8'h05);
      rd(8'hcc, v);
      @(posedge clk_sys_in);
      rc(8'hc9, 8'h01);
      // Fixed nine-bit mode at both rates.
      wr(8'h98, 8'h88);
      fork peer.recv(11, 16, frm); wr(8'h99, 8'ha5); join
      chk("frame", {2'b11, 8'ha5, 1'b0}, frm);
      rc(8'h98, 8'h8a);
      wr(8'h98, 8'h80);
      mode2_half_rate_in <= 1'b1;
      fork peer.recv(11, 32, frm); wr(8'h99, 8'h3c); join
      chk("frame", {2'b10, 8'h3c, 1'b0}, frm);
      // Shift mode transmit.
      wr(8'h98, 8'h00);
      fork peer.shift_recv(v); wr(8'h99, 8'h96); join
      chk("shift byte", 11'h096, {3'h0, v});
      repeat (8) @(posedge clk_sys_in);
      rc(8'h98, 8'h02);
      // Shift mode receive; the peer holds each bit one shift period.
      wr(8'h98, 8'h10);
      peer.send(11'h0a5, 8, 6);
      repeat (2) @(posedge clk_sys_in);
      rc(8'h98, 8'h11);
      rc(8'h99, 8'ha5);
      // Eight-bit mode on reload timer overflows: 96 clocks a bit.
      wr(8'hc8, 8'h34);
      wr(8'hca, 8'hff);
      wr(8'hcb, 8'hff);
      wr(8'hcd, 8'hff);
      wr(8'hcc, 8'hff);
      wr(8'h98, 8'h50);
      peer.send({1'b1, 8'h5a, 1'b0}, 10, 96);
      repeat (20) @(posedge clk_sys_in);
      rc(8'h98, 8'h55);
      rc(8'h99, 8'h5a);
      rc(8'hc8, 8'h34);
      peer.send({1'b1, 8'h11, 1'b0}, 10, 96);
      repeat (20) @(posedge clk_sys_in);
      rc(8'h99, 8'h5a);
      wr(8'h98, 8'h70);
      peer.send({1'b0, 8'h22, 1'b0}, 10, 96);
      repeat (20) @(posedge clk_sys_in);
      rc(8'h98, 8'h70);
      wr(8'h98, 8'h40);
      peer.send({1'b1, 8'h33, 1'b0}, 10, 96);
      repeat (20) @(posedge clk_sys_in);
      rc(8'h98, 8'h40);
      fork peer.recv(10, 96, frm); wr(8'h99, 8'hc3); join
      chk("frame", {2'b01, 8'hc3, 1'b0}, frm);
      rc(8'h98, 8'h42);
      // Timed nine-bit mode on the other source, filter on.
      wr(8'hc8, 8'h00);
      wr(8'h98, 8'hf0);
      peer.send({2'b01, 8'h81, 1'b0}, 11, 64);
      repeat (20) @(posedge clk_sys_in);
      rc(8'h98, 8'hf5);
      rc(8'h99, 8'h81);
      wr(8'h98, 8'hf0);
      peer.send({2'b10, 8'h42, 1'b0}, 11, 64);
      repeat (20) @(posedge clk_sys_in);
      rc(8'h98, 8'hf0);
      rc(8'h99, 8'h81);
      conclude();
   end
endmodule // debug_uart_reload_timer_test
`default_nettype wire
